// *** rtl/drpd_pkg.sv ***
// Package with command encodings, state types and timing counts of the refresh and power-down block.
package drpd_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int NUM_BANKS  = 4;
  localparam int BA_W       = 2;
  localparam int ROW_W      = 13;
  localparam int ADDR_W     = 13;
  localparam int A10_POS    = 10;
  localparam int CNT_W      = 16;

  // ==========================================================================
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  // ==========================================================================
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam int         CS_POS  = 3;

  // ==========================================================================
  // Timing in clock cycles at 250 MHz
  // ==========================================================================
  localparam int CLK_PS       = 4000;
  localparam int T_RFC_PS     = 127500;
  localparam int T_RP_PS      = 15000;
  localparam int T_RCD_PS     = 15000;
  localparam logic [CNT_W-1:0] T_RFC_CYC = CNT_W'((T_RFC_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] T_RP_CYC  = CNT_W'((T_RP_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] T_ACT_CYC = CNT_W'((T_RCD_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] T_MRD_CYC = 16'h0002;
  localparam logic [CNT_W-1:0] ONE_CYC   = 16'h0001;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    DRPD_RUN   = 3'b000,
    DRPD_PEND  = 3'b001,
    DRPD_PPD   = 3'b011,
    DRPD_APD   = 3'b010,
    DRPD_SREF  = 3'b110
  } drpd_mode_e;

  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } drpd_cmd_s;

  typedef struct packed {
    logic              mrs_we;
    logic [BA_W-1:0]   mrs_sel;
    logic [ADDR_W-1:0] mrs_op;
  } drpd_mrs_s;

  typedef struct packed {
    logic              busy;
    logic [CNT_W-1:0]  cnt;
    logic              is_ref;
  } drpd_op_s;

endpackage : drpd_pkg

// *** rtl/drpd_op_timer.sv ***
// Operation timer that keeps an internal operation running until its count has expired.
`timescale 1ns/1ps
`default_nettype none
module drpd_op_timer (
  // Clock and reset
  input  wire  logic                      clk_sys_i,
  input  wire  logic                      nrst_i,
  // Start request
  input  wire  logic                      start_i,
  input  wire  logic [drpd_pkg::CNT_W-1:0] len_i,
  input  wire  logic                      is_ref_i,
  // Status
  output logic                            busy_o,
  output logic                            ref_done_o
);

  drpd_pkg::drpd_op_s st_r;
  drpd_pkg::drpd_op_s st_nxt;
  logic               done_r;
  logic               done_nxt;

  // ==========================================================================
  // Countdown
  // ==========================================================================
  // A new start reloads the count, even while busy; the caller does not wait for idle.
  always_comb begin
    st_nxt   = st_r;
    done_nxt = 1'b0;
    if (start_i) begin
      st_nxt.busy   = 1'b1;
      st_nxt.cnt    = len_i;
      st_nxt.is_ref = is_ref_i;
    end else if (st_r.busy) begin
      if (st_r.cnt <= drpd_pkg::ONE_CYC) begin
        st_nxt.busy = 1'b0;
        st_nxt.cnt  = '0;
        done_nxt    = st_r.is_ref;
      end else begin
        st_nxt.cnt = st_r.cnt - drpd_pkg::ONE_CYC;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r   <= '0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy_o     = st_r.busy;
  assign ref_done_o = done_r;

endmodule : drpd_op_timer
`default_nettype wire

// *** rtl/drpd_core.sv ***
// Command decode, auto refresh counter and power-down control of a four-bank memory device.
// Contract
// - Refresh is LLLH with CKE high twice.
// - Refresh address comes from internal counter.
// - Power-down entry: CKE falls with NOP/deselect.
// - Running operation finishes before low power; self refresh entry does not wait for it.
// - Power-down gates buffers; DLL per exit mode (precharge power-down always stops the DLL).
// - Exit when CKE rises with NOP/deselect.
// - Commands decoded from CS RAS CAS WE CKE.
// - Bank address selects bank or mode register.
// - Self refresh entry and asynchronous exit.
`timescale 1ns/1ps
`default_nettype none
module drpd_core (
  // Clock and reset
  input  wire  logic                                  clk_sys_i,
  input  wire  logic                                  nrst_i,
  // Memory command pins, sampled on the rising edge
  input  wire  drpd_pkg::drpd_cmd_s                   cmd_i,
  input  wire  logic                                  fast_exit_i,
  // Array side
  output logic [drpd_pkg::NUM_BANKS-1:0]              bank_open_o,
  output logic                                        act_o,
  output logic                                        ref_o,
  output logic [drpd_pkg::BA_W-1:0]                   ref_bank_o,
  output logic [drpd_pkg::ROW_W-1:0]                  ref_row_o,
  output logic                                        rd_o,
  output logic                                        wr_o,
  output logic                                        auto_pre_o,
  output logic [drpd_pkg::BA_W-1:0]                   bank_o,
  output drpd_pkg::drpd_mrs_s                         mrs_o,
  // Power state
  output drpd_pkg::drpd_mode_e                        mode_o,
  output logic                                        buf_en_o,
  output logic                                        dll_en_o,
  output logic                                        illegal_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic                              cke_prev;
    drpd_pkg::drpd_mode_e              mode;
    logic [drpd_pkg::NUM_BANKS-1:0]    open;
    logic [drpd_pkg::BA_W+drpd_pkg::ROW_W-1:0] ref_ptr;
    logic                              act;
    logic                              refr;
    logic [drpd_pkg::BA_W-1:0]         ref_bank;
    logic [drpd_pkg::ROW_W-1:0]        ref_row;
    logic                              rd;
    logic                              wr;
    logic                              ap;
    logic [drpd_pkg::BA_W-1:0]         bank;
    drpd_pkg::drpd_mrs_s               mrs;
    logic                              buf_en;
    logic                              dll_en;
    logic                              illegal;
    logic                              pend_active;
  } drpd_st_s;

  drpd_st_s                 st_r;
  drpd_st_s                 st_nxt;
  logic                     op_busy;
  logic                     op_start;
  logic [drpd_pkg::CNT_W-1:0] op_len;
  logic                     op_is_ref;
  logic [3:0]               pins;
  logic                     nop_like;

  // Decode helper shared by the entry and exit checks.
  function automatic logic is_nop(input logic [3:0] p);
    is_nop = p[drpd_pkg::CS_POS] || (p == drpd_pkg::CMD_NOP);
  endfunction : is_nop

  assign pins     = {cmd_i.cs_n, cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
  assign nop_like = is_nop(pins);

  // Internal operations that may outlive a falling CKE are timed here.
  drpd_op_timer u_timer (
    .clk_sys_i  (clk_sys_i),
    .nrst_i     (nrst_i),
    .start_i    (op_start),
    .len_i      (op_len),
    .is_ref_i   (op_is_ref),
    .busy_o     (op_busy),
    .ref_done_o ()
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Commands only act with CKE high on both edges; the mode machine follows CKE.
  always_comb begin
    st_nxt           = st_r;
    st_nxt.cke_prev  = cmd_i.cke;
    st_nxt.act       = 1'b0;
    st_nxt.refr      = 1'b0;
    st_nxt.rd        = 1'b0;
    st_nxt.wr        = 1'b0;
    st_nxt.ap        = 1'b0;
    st_nxt.mrs.mrs_we = 1'b0;
    st_nxt.illegal   = 1'b0;
    op_start         = 1'b0;
    op_len           = '0;
    op_is_ref        = 1'b0;
    case (st_r.mode)
      drpd_pkg::DRPD_RUN: begin
        if (st_r.cke_prev && cmd_i.cke) begin
          st_nxt.bank = cmd_i.ba;
          case (pins)
            drpd_pkg::CMD_ACT: begin
              st_nxt.act                = 1'b1;
              st_nxt.open[cmd_i.ba]     = 1'b1;
              op_start                  = 1'b1;
              op_len                    = drpd_pkg::T_ACT_CYC;
            end
            drpd_pkg::CMD_RD, drpd_pkg::CMD_WR: begin
              st_nxt.rd = (pins == drpd_pkg::CMD_RD);
              st_nxt.wr = (pins == drpd_pkg::CMD_WR);
              st_nxt.ap = cmd_i.addr[drpd_pkg::A10_POS];
              if (cmd_i.addr[drpd_pkg::A10_POS]) begin
                st_nxt.open[cmd_i.ba] = 1'b0;
                op_start              = 1'b1;
                op_len                = drpd_pkg::T_RP_CYC;
              end
            end
            drpd_pkg::CMD_PRE: begin
              if (cmd_i.addr[drpd_pkg::A10_POS]) begin
                st_nxt.open = '0;
              end else begin
                st_nxt.open[cmd_i.ba] = 1'b0;
              end
              op_start = 1'b1;
              op_len   = drpd_pkg::T_RP_CYC;
            end
            drpd_pkg::CMD_REF: begin
              // External address is ignored; the pointer names the row.
              st_nxt.refr     = 1'b1;
              st_nxt.ref_bank = st_r.ref_ptr[drpd_pkg::BA_W-1:0];
              st_nxt.ref_row  = st_r.ref_ptr[drpd_pkg::BA_W+drpd_pkg::ROW_W-1:drpd_pkg::BA_W];
              st_nxt.ref_ptr  = st_r.ref_ptr + 1'b1;
              st_nxt.illegal  = |st_r.open;
              op_start        = 1'b1;
              op_len          = drpd_pkg::T_RFC_CYC;
              op_is_ref       = 1'b1;
            end
            drpd_pkg::CMD_MRS: begin
              st_nxt.mrs.mrs_we  = 1'b1;
              st_nxt.mrs.mrs_sel = cmd_i.ba;
              st_nxt.mrs.mrs_op  = cmd_i.addr;
              op_start           = 1'b1;
              op_len             = drpd_pkg::T_MRD_CYC;
            end
            default: begin
              st_nxt.illegal = !nop_like;
            end
          endcase
        end else if (st_r.cke_prev && !cmd_i.cke) begin
          if (pins == drpd_pkg::CMD_REF && !(|st_r.open)) begin
            // Self refresh keeps the device's own rows alive.
            st_nxt.mode   = drpd_pkg::DRPD_SREF;
            st_nxt.buf_en = 1'b0;
            st_nxt.dll_en = 1'b0;
          end else if (nop_like) begin
            st_nxt.pend_active = |st_r.open;
            st_nxt.mode        = drpd_pkg::DRPD_PEND;
          end else begin
            st_nxt.illegal = 1'b1;
          end
        end
      end
      drpd_pkg::DRPD_PEND: begin
        // Low power waits until the running operation has finished.
        if (cmd_i.cke && nop_like) begin
          st_nxt.mode = drpd_pkg::DRPD_RUN;
        end else if (!op_busy) begin
          st_nxt.buf_en = 1'b0;
          if (st_r.pend_active) begin
            st_nxt.mode   = drpd_pkg::DRPD_APD;
            st_nxt.dll_en = fast_exit_i;
          end else begin
            st_nxt.mode   = drpd_pkg::DRPD_PPD;
            st_nxt.dll_en = 1'b0;
          end
        end
      end
      drpd_pkg::DRPD_PPD, drpd_pkg::DRPD_APD: begin
        // Pins other than CKE are ignored until CKE rises; then a non-NOP is flagged.
        if (cmd_i.cke) begin
          st_nxt.mode   = drpd_pkg::DRPD_RUN;
          st_nxt.buf_en = 1'b1;
          st_nxt.dll_en = 1'b1;
          st_nxt.illegal = !nop_like;
        end
      end
      drpd_pkg::DRPD_SREF: begin
        // Exit is taken on CKE alone because exit is asynchronous to the command.
        if (cmd_i.cke) begin
          st_nxt.mode   = drpd_pkg::DRPD_RUN;
          st_nxt.buf_en = 1'b1;
          st_nxt.dll_en = 1'b1;
        end
      end
      default: begin
        st_nxt.mode = drpd_pkg::DRPD_RUN;
      end
    endcase
  end

  // ==========================================================================
  // Register
  // ==========================================================================
  // CKE is assumed low out of reset, as the init sequence requires.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r        <= '0;
      st_r.buf_en <= 1'b1;
      st_r.dll_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs straight from the state register
  // ==========================================================================
  assign bank_open_o = st_r.open;
  assign act_o       = st_r.act;
  assign ref_o       = st_r.refr;
  assign ref_bank_o  = st_r.ref_bank;
  assign ref_row_o   = st_r.ref_row;
  assign rd_o        = st_r.rd;
  assign wr_o        = st_r.wr;
  assign auto_pre_o  = st_r.ap;
  assign bank_o      = st_r.bank;
  assign mrs_o       = st_r.mrs;
  assign mode_o      = st_r.mode;
  assign buf_en_o    = st_r.buf_en;
  assign dll_en_o    = st_r.dll_en;
  assign illegal_o   = st_r.illegal;

endmodule : drpd_core
`default_nettype wire

// *** tb/drpd_props.sv ***
// Checker for command decode, refresh counter and power-down behaviour of the block.
`timescale 1ns/1ps
`default_nettype none
module drpd_props (
  // Clock and reset
  input wire logic                 clk_sys_i,
  input wire logic                 nrst_i,
  // Command side
  input wire drpd_pkg::drpd_cmd_s  cmd_i,
  input wire logic                 fast_exit_i,
  // Array side
  input wire logic [3:0]           bank_open_o,
  input wire logic                 act_o,
  input wire logic                 ref_o,
  input wire logic [1:0]           ref_bank_o,
  input wire logic [12:0]          ref_row_o,
  input wire logic                 rd_o,
  input wire logic                 wr_o,
  input wire logic                 auto_pre_o,
  input wire logic [1:0]           bank_o,
  input wire drpd_pkg::drpd_mrs_s  mrs_o,
  // Power state
  input wire drpd_pkg::drpd_mode_e mode_o,
  input wire logic                 buf_en_o,
  input wire logic                 dll_en_o,
  input wire logic                 illegal_o
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Own copy of the previous CKE, reset low like the device, so the first edge never decodes.
  logic        cke_r;
  logic        seen_r;
  logic [14:0] last_r;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cke_r <= 1'b0;
      seen_r <= 1'b0;
      last_r <= 15'h0000;
    end else begin
      cke_r <= cmd_i.cke;
      seen_r <= seen_r | ref_o;
      if (ref_o) last_r <= {ref_row_o, ref_bank_o};
    end
  end
  // Decode qualifiers shared by the properties.
  wire       run_ok = (mode_o == drpd_pkg::DRPD_RUN) && cke_r;
  wire [3:0] code   = {cmd_i.cs_n, cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================================
  // Properties
  // ==========================================================================
  a_act_decode: assert property (
    run_ok && cmd_i.cke && code == drpd_pkg::CMD_ACT |=> act_o && bank_o == $past(cmd_i.ba))
    else $error("activate not taken");
  a_ref_decode: assert property (
    run_ok && cmd_i.cke && code == drpd_pkg::CMD_REF |=> ref_o)
    else $error("refresh not taken");
  a_rd_autopre: assert property (
    run_ok && cmd_i.cke && code == drpd_pkg::CMD_RD |=> rd_o && auto_pre_o == $past(cmd_i.addr[10]))
    else $error("read or auto precharge wrong");
  a_mrs_select: assert property (
    run_ok && cmd_i.cke && code == drpd_pkg::CMD_MRS |=>
      mrs_o.mrs_we && mrs_o.mrs_sel == $past(cmd_i.ba) && mrs_o.mrs_op == $past(cmd_i.addr))
    else $error("mode register select wrong");
  a_ref_count: assert property (
    ref_o && seen_r |-> {ref_row_o, ref_bank_o} == 15'(last_r + 15'h0001))
    else $error("refresh address did not advance");
  a_pd_entry: assert property (
    run_ok && !cmd_i.cke && code == drpd_pkg::CMD_NOP |=> mode_o == drpd_pkg::DRPD_PEND)
    else $error("power-down entry missed");
  a_sref_entry: assert property (
    run_ok && !cmd_i.cke && code == drpd_pkg::CMD_REF && bank_open_o == 4'h0 |=> mode_o == drpd_pkg::DRPD_SREF)
    else $error("self refresh entry missed");
  a_pd_exit: assert property (
    (mode_o == drpd_pkg::DRPD_PPD || mode_o == drpd_pkg::DRPD_APD) && cmd_i.cke |=>
      mode_o == drpd_pkg::DRPD_RUN && buf_en_o && dll_en_o)
    else $error("power-down exit missed");
  a_ppd_class: assert property (
    mode_o == drpd_pkg::DRPD_PPD |-> bank_open_o == 4'h0 && !buf_en_o && !dll_en_o)
    else $error("precharge power-down wrong");
  a_apd_class: assert property (
    mode_o == drpd_pkg::DRPD_APD |-> bank_open_o != 4'h0 && !buf_en_o && dll_en_o == fast_exit_i)
    else $error("active power-down wrong");
  a_op_finish: assert property (
    act_o |-> (mode_o == drpd_pkg::DRPD_RUN || mode_o == drpd_pkg::DRPD_PEND) [*3])
    else $error("low power before activation ended");
endmodule : drpd_props
`default_nettype wire

// *** tb/drpd_ctl_model.sv ***
// Memory controller model that drives the command pins of the block.
`timescale 1ns/1ps
`default_nettype none
module drpd_ctl_model (
  // Clock
  input  wire logic                clk_sys_i,
  // Command pins
  output var drpd_pkg::drpd_cmd_s  cmd_o
);
  // Pins come up idle with CKE high and a NOP.
  initial cmd_o = {1'b1, drpd_pkg::CMD_NOP, 2'h0, 13'h0000};
  // One command for one edge, then a NOP with the address bus flipped so stale values never count.
  task automatic send(input logic cke, input logic [3:0] c, input logic [1:0] ba, input logic [12:0] a);
    @(posedge clk_sys_i);
    #1;
    cmd_o = {cke, c, ba, a};
    @(posedge clk_sys_i);
    #1;
    cmd_o = {cke, drpd_pkg::CMD_NOP, ~ba, ~a};
  endtask : send
  // Close all banks and let the precharge time run out before refreshing.
  task automatic refresh();
    send(1'b1, drpd_pkg::CMD_PRE, 2'h0, 13'h0400);
    repeat (drpd_pkg::T_RP_CYC) @(posedge clk_sys_i);
    send(1'b1, drpd_pkg::CMD_REF, 2'h0, 13'h0000);
    repeat (drpd_pkg::T_RFC_CYC) @(posedge clk_sys_i);
    #1;
  endtask : refresh
  // CKE falls with the given command and stays low, far below the refresh limit.
  // The clock never changes rate, so the loop stays locked throughout.
  task automatic pd_enter(input logic [3:0] c, input int n);
    send(1'b0, c, 2'h0, 13'h0000);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : pd_enter
  // CKE rises with a NOP and only NOPs follow until the exit latency is over.
  task automatic pd_exit();
    send(1'b1, drpd_pkg::CMD_NOP, 2'h0, 13'h0000);
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask : pd_exit
endmodule : drpd_ctl_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Testbench that walks decode, refresh and power-down scenarios of the block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================================
  // Pins and counters
  // ==========================================================================
  logic                 clk_sys_i, nrst_i, fast_exit_i;
  drpd_pkg::drpd_cmd_s  cmd;
  drpd_pkg::drpd_mrs_s  mrs;
  drpd_pkg::drpd_mode_e mode;
  logic [3:0]           bank_open;
  logic [1:0]           ref_bank, bank;
  logic [12:0]          ref_row;
  logic                 act, ref_p, rd, wr, ap, ill, buf_en, dll_en, ap_l;
  int                   error_cnt = 0, total_checks = 0, n_act = 0, n_ref = 0, n_rw = 0, n_ill = 0;
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // Pulses last one cycle, so counting them at each edge is exact.
  always @(posedge clk_sys_i) begin
    if (act) n_act <= n_act + 1;
    if (ref_p) n_ref <= n_ref + 1;
    if (rd || wr) n_rw <= n_rw + 1;
    if (rd || wr) ap_l <= ap;
    if (ill) n_ill <= n_ill + 1;
  end
  drpd_ctl_model drpd_ctl_model_i (.clk_sys_i(clk_sys_i), .cmd_o(cmd));
  drpd_core drpd_core_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_i(cmd), .fast_exit_i(fast_exit_i),
    .bank_open_o(bank_open), .act_o(act), .ref_o(ref_p), .ref_bank_o(ref_bank), .ref_row_o(ref_row),
    .rd_o(rd), .wr_o(wr), .auto_pre_o(ap), .bank_o(bank), .mrs_o(mrs), .mode_o(mode),
    .buf_en_o(buf_en), .dll_en_o(dll_en), .illegal_o(ill));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Two refreshes must walk the internal address counter up from zero.
  task automatic t_refresh();
    drpd_ctl_model_i.refresh();
    chk(16'(n_ref), 16'h0001);
    chk(16'({ref_row, ref_bank}), 16'h0000);
    drpd_ctl_model_i.refresh();
    chk(16'(n_ref), 16'h0002);
    chk(16'({ref_row, ref_bank}), 16'h0001);
  endtask : t_refresh
  // Activate, read, write with auto precharge and a mode register write.
  task automatic t_access();
    drpd_ctl_model_i.send(1'b1, drpd_pkg::CMD_ACT, 2'h2, 13'h0123);
    drpd_ctl_model_i.send(1'b1, drpd_pkg::CMD_RD, 2'h2, 13'h0010);
    chk(16'({bank_open, bank}), 16'h0012);
    chk(16'({ap, 4'(n_act)}), 16'h0001);
    drpd_ctl_model_i.send(1'b1, drpd_pkg::CMD_WR, 2'h2, 13'h0410);
    // The latched flag and the pulse count settle one edge after the write pulse.
    @(posedge clk_sys_i);
    #1;
    chk(16'({ap_l, 4'(n_rw)}), 16'h0012);
    repeat (10) @(posedge clk_sys_i);
    #1;
    chk(16'(bank_open), 16'h0000);
    drpd_ctl_model_i.send(1'b1, drpd_pkg::CMD_MRS, 2'h3, 13'h0A5C);
    chk(16'({mrs.mrs_sel, mrs.mrs_op}), 16'h6A5C);
  endtask : t_access
  // Active power-down, first requested while the activation still runs; fast then slow exit.
  task automatic t_active_pd();
    drpd_ctl_model_i.send(1'b1, drpd_pkg::CMD_ACT, 2'h1, 13'h0042);
    for (int f = 1; f >= 0; f--) begin
      fast_exit_i = f[0];
      drpd_ctl_model_i.pd_enter(drpd_pkg::CMD_NOP, 8);
      chk(16'(mode), 16'(drpd_pkg::DRPD_APD));
      chk(16'({buf_en, dll_en}), 16'({1'b0, f[0]}));
      drpd_ctl_model_i.pd_exit();
      chk(16'({mode, buf_en, dll_en}), 16'h0003);
    end
    drpd_ctl_model_i.send(1'b1, drpd_pkg::CMD_PRE, 2'h0, 13'h0400);
    repeat (8) @(posedge clk_sys_i);
  endtask : t_active_pd
  // Precharge power-down and self refresh from all banks idle.
  task automatic t_idle_pd();
    for (int k = 0; k < 2; k++) begin
      drpd_ctl_model_i.pd_enter(k ? drpd_pkg::CMD_REF : drpd_pkg::CMD_NOP, 8);
      chk(16'(mode), k ? 16'(drpd_pkg::DRPD_SREF) : 16'(drpd_pkg::DRPD_PPD));
      chk(16'({buf_en, dll_en}), 16'h0000);
      drpd_ctl_model_i.pd_exit();
      chk(16'(mode), 16'(drpd_pkg::DRPD_RUN));
    end
  endtask : t_idle_pd
  // A refresh with a bank left open is flagged.
  task automatic t_open_ref();
    drpd_ctl_model_i.send(1'b1, drpd_pkg::CMD_ACT, 2'h0, 13'h0001);
    repeat (4) @(posedge clk_sys_i);
    drpd_ctl_model_i.send(1'b1, drpd_pkg::CMD_REF, 2'h0, 13'h0000);
    chk(16'({ill, 4'(n_ill)}), 16'h0010);
  endtask : t_open_ref
  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    nrst_i = 1'b0;
    fast_exit_i = 1'b1;
    repeat (20) @(posedge clk_sys_i);
    #1;
    nrst_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    t_refresh();
    t_access();
    t_active_pd();
    t_idle_pd();
    t_open_ref();
    complete_run();
  end
  // The scenarios need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    error_cnt++;
    complete_run();
  end
endmodule : tb_top
bind drpd_core drpd_props drpd_props_i (
  .clk_sys_i   (clk_sys_i),
  .nrst_i      (nrst_i),
  .cmd_i       (cmd_i),
  .fast_exit_i (fast_exit_i),
  .bank_open_o (bank_open_o),
  .act_o       (act_o),
  .ref_o       (ref_o),
  .ref_bank_o  (ref_bank_o),
  .ref_row_o   (ref_row_o),
  .rd_o        (rd_o),
  .wr_o        (wr_o),
  .auto_pre_o  (auto_pre_o),
  .bank_o      (bank_o),
  .mrs_o       (mrs_o),
  .mode_o      (mode_o),
  .buf_en_o    (buf_en_o),
  .dll_en_o    (dll_en_o),
  .illegal_o   (illegal_o)
);
`default_nettype wire
